// ===== verilog/instruction_word_decoder.sv
// Fetches, decodes and executes 14-bit instruction words for an 8-bit core.
// Assumes program memory answers o_pc with i_instr in the same cycle.
`timescale 1ns/100ps
`include "decoder_map.svh"
module instruction_word_decoder
	import decoder_pkg::*;
#(
	parameter int STACK_DEPTH = 8
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [13:0] i_instr,
	input  wire logic [1:0]  i_pc_latch_bits,
	input  wire logic        i_prescaler_on_timer,
	output logic      [12:0] o_pc,
	output logic             o_fetch_strobe,
	output logic             o_cycle_start,
	output logic             o_nop_cycle,
	output logic      [7:0]  o_accumulator,
	output logic             o_msb_overflow_flag,
	output logic             o_nibble_overflow_flag,
	output logic             o_result_null_flag,
	output logic             o_prescaler_clear,
	output logic             o_port_change_clear
);
	localparam int SPW = $clog2(STACK_DEPTH);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	quarter_e    q_r;
	quarter_e    q_nxt;
	instr_t      ir_r;
	logic        flush_r;
	logic [12:0] pc_r;
	logic [12:0] pc_nxt;
	logic [7:0]  acc_r;
	logic        c_r;
	logic        hc_r;
	logic        z_r;
	logic [12:0] stk_r [STACK_DEPTH];
	logic [SPW-1:0] sp_r;

	// ------------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------------
	wire [1:0]  fmt   = ir_r[13:12];
	wire [3:0]  op    = ir_r[11:8];
	wire        dbit  = ir_r[7];
	wire [6:0]  faddr = ir_r[6:0];
	wire [2:0]  bsel  = ir_r[9:7];
	wire [1:0]  bop   = ir_r[11:10];
	wire [7:0]  kbyte = ir_r[7:0];
	wire [10:0] kjump = ir_r[10:0];
	wire        last_q = (q_r == Q4);
	wire        commit = last_q && !flush_r;
	wire [7:0]  fdata;

	// ------------------------------------------------------------------
	// Shared adder and subtractor
	// ------------------------------------------------------------------
	wire       lit_fmt = (fmt == `FMT_LIT);
	wire [7:0] add_a   = lit_fmt ? kbyte : fdata;
	wire [8:0] add9    = {1'b0, add_a} + {1'b0, acc_r};
	wire [4:0] addn    = {1'b0, add_a[3:0]} + {1'b0, acc_r[3:0]};
	wire [8:0] sub9    = {1'b0, fdata} - {1'b0, acc_r};
	wire       subn_ok = (fdata[3:0] >= acc_r[3:0]);
	wire [7:0] bmask   = 8'h01 << bsel;
	wire       bitv    = fdata[bsel];

	// ------------------------------------------------------------------
	// Execute
	// ------------------------------------------------------------------
	logic [7:0] res;
	logic       c_n;
	logic       hc_n;
	logic       u_c;
	logic       u_hc;
	logic       u_z;
	logic       to_f;
	logic       to_w;
	logic       file_op;
	logic       skip;
	logic       jump;
	logic       call;
	logic       ret;

	always_comb begin
		res     = fdata;
		c_n     = c_r;
		hc_n    = hc_r;
		u_c     = 1'b0;
		u_hc    = 1'b0;
		u_z     = 1'b0;
		to_f    = 1'b0;
		to_w    = 1'b0;
		file_op = 1'b0;
		skip    = 1'b0;
		jump    = 1'b0;
		call    = 1'b0;
		ret     = 1'b0;
		case (fmt)
			`FMT_BYTE: begin
				to_f    = dbit;
				to_w    = !dbit;
				file_op = dbit || (op != `OP_STORE && op != `OP_ZERO);
				case (op)
					`OP_STORE: begin
						res  = acc_r;
						to_w = 1'b0;
					end
					`OP_ZERO: begin
						res = 8'h00;
						u_z = 1'b1;
					end
					`OP_SUB: begin
						res  = sub9[7:0];
						c_n  = !sub9[8];
						hc_n = subn_ok;
						u_c  = 1'b1;
						u_hc = 1'b1;
						u_z  = 1'b1;
					end
					`OP_ADD: begin
						res  = add9[7:0];
						c_n  = add9[8];
						hc_n = addn[4];
						u_c  = 1'b1;
						u_hc = 1'b1;
						u_z  = 1'b1;
					end
					`OP_OR: begin
						res = fdata | acc_r;
						u_z = 1'b1;
					end
					`OP_AND: begin
						res = fdata & acc_r;
						u_z = 1'b1;
					end
					`OP_XOR: begin
						res = fdata ^ acc_r;
						u_z = 1'b1;
					end
					`OP_INV: begin
						res = ~fdata;
						u_z = 1'b1;
					end
					`OP_MOVE: begin
						u_z = 1'b1;
					end
					`OP_DEC: begin
						res = fdata - 8'h01;
						u_z = 1'b1;
					end
					`OP_INC: begin
						res = fdata + 8'h01;
						u_z = 1'b1;
					end
					`OP_DECSZ: begin
						res  = fdata - 8'h01;
						skip = (res == 8'h00);
					end
					`OP_INCSZ: begin
						res  = fdata + 8'h01;
						skip = (res == 8'h00);
					end
					`OP_RRC: begin
						res = {c_r, fdata[7:1]};
						c_n = fdata[0];
						u_c = 1'b1;
					end
					`OP_RLC: begin
						res = {fdata[6:0], c_r};
						c_n = fdata[7];
						u_c = 1'b1;
					end
					`OP_SWAP: begin
						res = {fdata[3:0], fdata[7:4]};
					end
					default: begin
						res = fdata;
					end
				endcase
			end
			`FMT_BIT: begin
				file_op = 1'b1;
				case (bop)
					`BOP_CLR: begin
						res  = fdata & ~bmask;
						to_f = 1'b1;
					end
					`BOP_SET: begin
						res  = fdata | bmask;
						to_f = 1'b1;
					end
					`BOP_SKIP_LOW: begin
						skip = !bitv;
					end
					default: begin
						skip = bitv;
					end
				endcase
			end
			`FMT_CTRL: begin
				jump = 1'b1;
				call = !ir_r[11];
			end
			default: begin
				res  = kbyte;
				to_w = 1'b1;
				if (ir_r[11:9] == `LIT_ADD3) begin
					res  = add9[7:0];
					c_n  = add9[8];
					hc_n = addn[4];
					u_c  = 1'b1;
					u_hc = 1'b1;
					u_z  = 1'b1;
				end else if (op == `LIT_AND) begin
					res = kbyte & acc_r;
					u_z = 1'b1;
				end else if (op == `LIT_OR) begin
					res = kbyte | acc_r;
					u_z = 1'b1;
				end else if (ir_r[11:10] == `LIT_MOVE2) begin
					res = kbyte;
				end else if (ir_r[11:10] == `LIT_RET2) begin
					ret = 1'b1;
				end else begin
					to_w = 1'b0;
				end
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	wire we   = commit && to_f && file_op;
	wire take = commit && (skip || jump || ret);

	file_register_mem #(
		.AW (7),
		.DW (8)
	) u_file (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_rd_addr (faddr),
		.o_rd_data (fdata),
		.i_we      (we),
		.i_wr_addr (faddr),
		.i_wr_data (res)
	);

	// ------------------------------------------------------------------
	// Sequencing
	// ------------------------------------------------------------------
	// four quarters per cycle
	assign q_nxt = quarter_e'(q_r + 2'b01);

	assign pc_nxt = (commit && ret)  ? stk_r[sp_r] :
			(commit && jump) ? {i_pc_latch_bits, kjump} :
			pc_r + 13'h0001;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q_r <= Q1;
		end else begin
			q_r <= q_nxt;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ir_r    <= `NOP_WORD;
			flush_r <= 1'b1;
			pc_r    <= `PC_RESET;
		end else if (last_q) begin
			ir_r    <= i_instr;
			flush_r <= take;
			pc_r    <= pc_nxt;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sp_r <= '0;
		end else if (commit && call) begin
			sp_r <= sp_r + SPW'(1);
		end else if (commit && ret) begin
			sp_r <= sp_r - SPW'(1);
		end
	end

	// The stack wraps silently when it overflows, as the hardware does.
	always_ff @(posedge i_clk) begin
		if (commit && call) begin
			stk_r[sp_r + SPW'(1)] <= pc_r;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			acc_r <= 8'h00;
		end else if (commit && to_w) begin
			acc_r <= res;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			c_r  <= 1'b0;
			hc_r <= 1'b0;
			z_r  <= 1'b0;
		end else if (commit) begin
			c_r  <= u_c  ? c_n  : c_r;
			hc_r <= u_hc ? hc_n : hc_r;
			z_r  <= u_z  ? (res == 8'h00) : z_r;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign o_pc                   = pc_r;
	assign o_fetch_strobe         = last_q;
	assign o_cycle_start          = (q_r == Q1);
	assign o_nop_cycle            = flush_r;
	assign o_accumulator          = acc_r;
	assign o_msb_overflow_flag    = c_r;
	assign o_nibble_overflow_flag = hc_r;
	assign o_result_null_flag     = z_r;

	assign o_port_change_clear = (q_r == Q2) && !flush_r && file_op &&
				     (faddr == `ADDR_SECOND_PORT);

	assign o_prescaler_clear = we && (faddr == `ADDR_TIMER_ZERO) &&
				   i_prescaler_on_timer;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_quarters;
		q_r == Q2 ##1 q_r == Q3 ##1 q_r == Q4 ##1 q_r == Q1;
	endsequence

	sequence s_nop_cycle;
		(flush_r && !we && !o_port_change_clear) [*4];
	endsequence

	a_quarter_order: assert property (
		q_r == Q1 |=> s_quarters)
		else $error("Instruction cycle is not four quarters.");

	a_taken_flush: assert property (
		(last_q && take) |=> s_nop_cycle)
		else $error("Taken skip or branch did not flush one cycle.");

	a_skip_zero: assert property (
		(commit && fmt == `FMT_BYTE && op == `OP_INCSZ && fdata == 8'hff)
		|=> flush_r && pc_r == $past(pc_r) + 13'h0001)
		else $error("Increment to zero did not skip.");

	a_jump_target: assert property (
		(commit && jump) |=> pc_r == {$past(i_pc_latch_bits), $past(kjump)})
		else $error("Jump target not formed from latch and literal.");

	a_call_push: assert property (
		(commit && call) |=> stk_r[sp_r] == $past(pc_r) &&
			sp_r == $past(sp_r) + SPW'(1))
		else $error("Call did not push the return address.");

	a_acc_dest: assert property (
		(commit && fmt == `FMT_BYTE && !dbit && op != `OP_STORE)
		|=> acc_r == $past(res) ##3 acc_r == $past(res, 4))
		else $error("Accumulator destination not written.");

	a_null_flag: assert property (
		(commit && u_z) |=> o_result_null_flag == ($past(res) == 8'h00))
		else $error("Result null flag wrong after update.");

	a_swap_flags: assert property (
		(commit && fmt == `FMT_BYTE && op == `OP_SWAP)
		|=> $stable(c_r) && $stable(z_r) && $stable(hc_r))
		else $error("Swap changed a flag.");

	a_port_clear: assert property (
		(q_r == Q1 && !flush_r && fmt == `FMT_BYTE && op == `OP_ZERO && dbit &&
		 faddr == `ADDR_SECOND_PORT) |=> o_port_change_clear)
		else $error("Zeroing second port did not read it.");

	a_prescale_clear: assert property (
		(q_r == Q3 && !flush_r && fmt == `FMT_BYTE && op == `OP_STORE && dbit &&
		 faddr == `ADDR_TIMER_ZERO && i_prescaler_on_timer) |=> o_prescaler_clear)
		else $error("Timer write did not clear the prescaler.");
endmodule // instruction_word_decoder

// ===== verilog/decoder_map.svh
// Constants for the instruction word decoder: opcodes, addresses, timing.
// Assumes it is included once per compile unit, before the package users.
//
// Notes on behaviour
// - Fourteen-bit words split into opcode and operands.
// - Result bit 0 to accumulator, 1 to register.
// - Register selector is a 7-bit file address.
// - Bit index picks one bit of register.
// - Literal is 8 bits, or 11 for transfers.
// - One instruction cycle is four oscillator periods.
// - One cycle; taken skip or branch takes two.
// - File instructions always read before they write.
// - Zeroing second port reads it, clearing port change.
// - Byte format; add and subtract set three flags.
// - And, or, xor, invert set only null flag.
// - Inc/dec set null; skip forms skip on zero.
// - Rotates go through carry; swap touches no flags.
// - Move sets null; store; zeroing sets null flag.
// - Bit format: clear, set, skip-if-low, skip-if-high.
// - Literal add sets three flags; and/or set null.
// - Load literal; return-with-literal takes two cycles.
// - Call and jump carry 11-bit target, two cycles.
// - Writing timer zero clears its assigned prescaler.
// - Upper program counter bits from latch bits 4:3.
// - Call pushes program counter plus one first.
`ifndef DECODER_MAP_SVH
`define DECODER_MAP_SVH

// ----------------------------------------------------------------------
// Formats
// ----------------------------------------------------------------------
`define FMT_BYTE        2'h0
`define FMT_BIT         2'h1
`define FMT_CTRL        2'h2
`define FMT_LIT         2'h3

// ----------------------------------------------------------------------
// Byte-oriented operations
// ----------------------------------------------------------------------
`define OP_STORE        4'h0
`define OP_ZERO         4'h1
`define OP_SUB          4'h2
`define OP_DEC          4'h3
`define OP_OR           4'h4
`define OP_AND          4'h5
`define OP_XOR          4'h6
`define OP_ADD          4'h7
`define OP_MOVE         4'h8
`define OP_INV          4'h9
`define OP_INC          4'ha
`define OP_DECSZ        4'hb
`define OP_RRC          4'hc
`define OP_RLC          4'hd
`define OP_SWAP         4'he
`define OP_INCSZ        4'hf

// ----------------------------------------------------------------------
// Bit-oriented and literal operations
// ----------------------------------------------------------------------
`define BOP_CLR         2'h0
`define BOP_SET         2'h1
`define BOP_SKIP_LOW    2'h2
`define BOP_SKIP_HIGH   2'h3
`define LIT_ADD3        3'h7
`define LIT_AND         4'h9
`define LIT_OR          4'h8
`define LIT_MOVE2       2'h0
`define LIT_RET2        2'h1

// ----------------------------------------------------------------------
// Addresses, reset values and timing
// ----------------------------------------------------------------------
`define ADDR_TIMER_ZERO 7'h01
`define ADDR_SECOND_PORT 7'h06
`define PC_RESET        13'h0000
`define NOP_WORD        14'h0000
`define OSC_PERIOD_NS   25
`define OSC_PER_CYCLE   4
`define INSTR_CYCLE_NS  (`OSC_PER_CYCLE * `OSC_PERIOD_NS)

`endif

// ===== verilog/decoder_pkg.sv
// Types shared by the instruction word decoder and its bench.
// Assumes the map header is compiled alongside.
package decoder_pkg;
	typedef enum logic [1:0] {
		Q1 = 2'b00,
		Q2 = 2'b01,
		Q3 = 2'b10,
		Q4 = 2'b11
	} quarter_e;
	typedef logic [13:0] instr_t;
endpackage

// ===== verilog/file_register_mem.sv
// Data memory holding the file registers, with registered read data.
// Assumes one clock and that the caller keeps the read address steady.
`timescale 1ns/100ps
module file_register_mem #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	input  wire logic [AW-1:0] i_rd_addr,
	output logic      [DW-1:0] o_rd_data,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_wr_addr,
	input  wire logic [DW-1:0] i_wr_data
);
	logic [DW-1:0] mem_r [2**AW];
	logic [DW-1:0] rd_r;

	// Contents are left unreset; only the read register has a defined value.
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem_r[i_wr_addr] <= i_wr_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rd_r <= '0;
		end else begin
			rd_r <= mem_r[i_rd_addr];
		end
	end

	assign o_rd_data = rd_r;
endmodule // file_register_mem

// ===== verif/program_store_model.sv
// Program memory model that answers the decoder's fetch address.
// Assumes the bench fills the word array while the decoder is in reset.
`timescale 1ns/100ps
module program_store_model (
	input  wire logic [12:0] i_pc,
	output logic      [13:0] o_word
);
	// ------------------------------------------------------------
	// Word store
	// ------------------------------------------------------------
	// Only 32 words are held, so the upper address bits alias.
	// This keeps page-bit tests short at the cost of a tiny store.
	logic [13:0] mem [0:31];

	assign o_word = mem[i_pc[4:0]];
endmodule // program_store_model

// ===== verif/instruction_word_decoder_tb_top.sv
// Self-checking bench for the instruction word decoder.
// Assumes the decoder package and map header are compiled first.
`timescale 1ns/100ps
module instruction_word_decoder_tb_top;
	import decoder_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] fv;
		logic       c;
		logic       hc;
		logic       z;
		logic       wr;
		logic       rd;
		logic       skip;
	} exp_s;
	logic        i_clk                = 1'b0;
	logic        i_rst_n              = 1'b0;
	logic [1:0]  i_pc_latch_bits      = 2'h0;
	logic        i_prescaler_on_timer = 1'b0;
	logic [13:0] i_instr;
	logic [12:0] o_pc;
	logic [7:0]  o_accumulator;
	logic        o_fetch_strobe;
	logic        o_cycle_start;
	logic        o_nop_cycle;
	logic        o_msb_overflow_flag;
	logic        o_nibble_overflow_flag;
	logic        o_result_null_flag;
	logic        o_prescaler_clear;
	logic        o_port_change_clear;
	int          err_count = 0;
	int          checked   = 0;
	int          cyc       = 0;
	int          n_flush;
	int          n_fetch;
	int          n_port;
	int          n_presc;
	logic [6:0]  addrs [4] = '{7'h20, 7'h01, 7'h06, 7'h7f};
	logic [3:0]  lits  [6] = '{4'h0, 4'h3, 4'h8, 4'h9, 4'he, 4'hf};

	always #12.5 i_clk = ~i_clk;

	program_store_model pm (
		.i_pc   (o_pc),
		.o_word (i_instr)
	);

	instruction_word_decoder dut (
		.i_clk                  (i_clk),
		.i_rst_n                (i_rst_n),
		.i_instr                (i_instr),
		.i_pc_latch_bits        (i_pc_latch_bits),
		.i_prescaler_on_timer   (i_prescaler_on_timer),
		.o_pc                   (o_pc),
		.o_fetch_strobe         (o_fetch_strobe),
		.o_cycle_start          (o_cycle_start),
		.o_nop_cycle            (o_nop_cycle),
		.o_accumulator          (o_accumulator),
		.o_msb_overflow_flag    (o_msb_overflow_flag),
		.o_nibble_overflow_flag (o_nibble_overflow_flag),
		.o_result_null_flag     (o_result_null_flag),
		.o_prescaler_clear      (o_prescaler_clear),
		.o_port_change_clear    (o_port_change_clear)
	);

	// ------------------------------------------------------------
	// Reporting
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// A hung handshake would otherwise stall the run for good.
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// Reference model of one executed word
	// ------------------------------------------------------------
	function automatic exp_s step(input logic [13:0] wd, input exp_s p);
		exp_s       r;
		logic [8:0] s;
		logic [7:0] v;
		logic [7:0] w;
		logic [7:0] f;
		logic [7:0] k;
		r = p;
		r.wr = 1'b0;
		r.rd = 1'b0;
		r.skip = 1'b0;
		w = p.acc;
		f = p.fv;
		k = wd[7:0];
		v = 8'h00;
		s = w + k;
		case (wd[13:12])
		2'b00: begin
			case (wd[11:8])
			4'h0: v = w;
			4'h1: v = 8'h00;
			4'h2: begin
				v = f - w;
				r.c = f >= w;
				r.hc = f[3:0] >= w[3:0];
			end
			4'h3, 4'hb: v = f - 8'h01;
			4'h4: v = w | f;
			4'h5: v = w & f;
			4'h6: v = w ^ f;
			4'h7: begin
				s = f + w;
				v = s[7:0];
				r.c = s[8];
				r.hc = (f[3:0] + w[3:0]) > 5'h10 - 5'h01;
			end
			4'h8: v = f;
			4'h9: v = ~f;
			4'ha, 4'hf: v = f + 8'h01;
			4'hc: begin
				v = {p.c, f[7:1]};
				r.c = f[0];
			end
			4'hd: begin
				v = {f[6:0], p.c};
				r.c = f[7];
			end
			default: v = {f[3:0], f[7:4]};
			endcase
			r.rd = wd[11:8] > 4'h1 || wd[7];
			if (wd[11:8] >= 4'h1 && wd[11:8] <= 4'ha) r.z = v == 8'h00;
			r.skip = (wd[11:8] == 4'hb || wd[11:8] == 4'hf) && v == 8'h00;
			if (wd[7]) begin
				r.fv = v;
				r.wr = 1'b1;
			end else begin
				r.acc = v;
			end
		end
		2'b01: begin
			r.rd = 1'b1;
			r.wr = !wd[11];
			if (!wd[11]) r.fv[wd[9:7]] = wd[10];
			r.skip = wd[11] && f[wd[9:7]] == wd[10];
		end
		default: begin
			if (wd[11:9] == 3'h7) begin
				r.acc = s[7:0];
				r.c = s[8];
				r.hc = (w[3:0] + k[3:0]) > 5'h10 - 5'h01;
			end
			else if (wd[11:8] == 4'h9) r.acc = w & k;
			else if (wd[11:8] == 4'h8) r.acc = w | k;
			else if (!wd[11]) r.acc = k;
			if (wd[11:9] == 3'h7 || wd[11:9] == 3'h4) r.z = r.acc == 8'h00;
		end
		endcase
		return r;
	endfunction

	function automatic logic [7:0] rnd8();
		return 8'($urandom);
	endfunction

	function automatic logic [13:0] rand_op();
		logic [3:0] code;
		code = 4'($urandom_range(15));
		case ($urandom_range(2))
		0: return {2'b00, code, (code == 4'h0) | $urandom_range(1) == 1, 7'h00};
		1: return {2'b01, 5'($urandom), 7'h00};
		default: return {2'b11, lits[$urandom_range(5)], rnd8()};
		endcase
	endfunction

	// ------------------------------------------------------------
	// Program runs
	// ------------------------------------------------------------
	task automatic run_prog();
		n_flush = 0;
		n_fetch = 0;
		n_port = 0;
		n_presc = 0;
		i_rst_n = 1'b0;
		repeat (2) @(negedge i_clk);
		i_rst_n = 1'b1;
		for (int i = 0; i < 80; i++) begin
			@(negedge i_clk);
			if (i < 48 && o_cycle_start === 1'b1 && o_nop_cycle === 1'b1) n_flush++;
			if (i < 48 && o_fetch_strobe === 1'b1) n_fetch++;
			if (o_port_change_clear === 1'b1) n_port++;
			if (o_prescaler_clear === 1'b1) n_presc++;
		end
	endtask

	// Seeds flags with a literal add, stores a file value, then runs op.
	task automatic byte_case(input logic [13:0] op, input logic [7:0] p, input logic [7:0] q,
			input logic [7:0] fv, input logic [7:0] wv, input logic [6:0] fa);
		exp_s        r;
		logic [13:0] prog [6];
		logic [13:0] rb;
		int          n_rd;
		int          n_wr;
		logic        ps;
		ps = 1'($urandom);
		prog = '{14'h3000 | p, 14'h3e00 | q, 14'h3000 | fv, {7'h01, fa}, 14'h3000 | wv,
			op[13] ? op : op | {7'h00, fa}};
		rb = {7'h10, fa};
		foreach (pm.mem[j]) pm.mem[j] = 14'h0000;
		r = '0;
		n_rd = 0;
		n_wr = 0;
		for (int i = 0; i < 6; i++) begin
			pm.mem[i] = prog[i];
			r = step(prog[i], r);
			n_rd += r.rd;
			n_wr += r.wr;
		end
		pm.mem[6] = 14'h280a;
		pm.mem[7] = 14'h2814;
		pm.mem[11] = 14'h280b;
		pm.mem[21] = 14'h2815;
		pm.mem[r.skip ? 20 : 10] = r.wr ? rb : 14'h0000;
		i_pc_latch_bits = 2'h0;
		i_prescaler_on_timer = ps;
		if (r.wr) begin
			rb = {r.skip, 1'b0};
			r = step({7'h10, fa}, r);
			n_rd += r.rd;
			r.skip = rb[1];
		end
		run_prog();
		check("accumulator", o_accumulator, r.acc);
		check("carry", o_msb_overflow_flag, r.c);
		check("digit carry", o_nibble_overflow_flag, r.hc);
		check("zero", o_result_null_flag, r.z);
		check("skip path", o_pc >= 13'h0010, r.skip);
		check("flushed cycles", n_flush, 2 + r.skip);
		check("fetches", n_fetch, 12);
		check("port reads", n_port, fa == 7'h06 ? n_rd : 0);
		check("prescaler clears", n_presc, (fa == 7'h01 && ps) ? n_wr : 0);
	endtask

	task automatic call_case(input logic [1:0] lb, input logic [7:0] k, input logic [7:0] q);
		logic [8:0] s;
		s = k + q;
		foreach (pm.mem[j]) pm.mem[j] = 14'h0000;
		pm.mem[0] = 14'h2008;
		pm.mem[1] = 14'h3e00 | q;
		pm.mem[2] = 14'h2802;
		pm.mem[8] = 14'h3400 | k;
		i_pc_latch_bits = lb;
		run_prog();
		check("return value", o_accumulator, s[7:0]);
		check("carry", o_msb_overflow_flag, s[8]);
		check("page bits", o_pc[12:11], lb);
		check("flushed cycles", n_flush, 5);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(72));
		repeat (12) @(negedge i_clk);
		byte_case(14'h0700, 8'h0f, 8'h01, 8'hff, 8'h01, 7'h20);
		byte_case(14'h0200, 8'h01, 8'h02, 8'h35, 8'h35, 7'h06);
		byte_case(14'h0200, 8'h80, 8'h80, 8'h30, 8'h31, 7'h7f);
		byte_case(14'h0b80, 8'h00, 8'h00, 8'h01, 8'h44, 7'h06);
		byte_case(14'h0f00, 8'h10, 8'h20, 8'hff, 8'h00, 7'h01);
		byte_case(14'h1800, 8'h00, 8'h00, 8'hfe, 8'h00, 7'h20);
		byte_case(14'h1f80, 8'h00, 8'h00, 8'h80, 8'h00, 7'h06);
		byte_case(14'h0180, 8'h00, 8'h01, 8'h5a, 8'h00, 7'h01);
		byte_case(14'h3e80, 8'h00, 8'h00, 8'h00, 8'h80, 7'h20);
		byte_case(14'h0180, 8'h00, 8'h03, 8'h77, 8'h00, 7'h06);
		// Unassigned literal codes must leave the accumulator and flags alone.
		byte_case(14'h3a5a, 8'h00, 8'h05, 8'h00, 8'h33, 7'h20);
		byte_case(14'h3d5a, 8'h00, 8'h07, 8'h00, 8'h44, 7'h20);
		// Every byte code with both destinations except store with accumulator destination, every bit op and bit.
		for (int c = 1; c < 32; c++) begin
			byte_case(14'(c << 7), rnd8(), rnd8(), rnd8(), rnd8(), addrs[c % 4]);
		end
		for (int b = 32; b < 64; b++) begin
			byte_case(14'(b << 7), rnd8(), rnd8(), rnd8(), rnd8(), addrs[b % 4]);
		end
		for (int l = 0; l < 6; l++) begin
			byte_case({2'b11, lits[l], rnd8()}, rnd8(), rnd8(), rnd8(), rnd8(), 7'h20);
		end
		for (int l = 0; l < 4; l++) begin
			call_case(2'(l), rnd8(), rnd8());
		end
		for (int n = 0; n < 150; n++) begin
			byte_case(rand_op(), rnd8(), rnd8(), rnd8(), rnd8(), addrs[2'($urandom)]);
		end
		give_verdict();
	end
endmodule // instruction_word_decoder_tb_top
